//--- hw/dctc_capture_regs.sv
`timescale 1ns/1ps
`include "dctc_params.svh"
// What this block does
// - rising edge stores 64-bit system time
// - falling edge stores 64-bit system time
// - low byte read snapshots upper bits, per port
// - bus read of rise clears flag, owner 0
// - host read clears rise flag, ack off
// - host writes ignored while write-ack off
// - host write clears flag when write-ack on
// - host ack clears falling flag likewise
// - record local time at event frame start
// - record local time on host start event
// - 32-bit stamps snapshot upper bits per port
// - mode bit: continuous or first-edge only
// - flag set only in single-event mode
module dctc_capture_regs (
    // clock and synchronous reset
    input wire logic clk,
    input wire logic sys_rst,
    // capture pin and the two time bases
    input wire logic capture_in,
    input wire logic [63:0] system_time,
    input wire logic [31:0] local_time,
    // one-cycle pulses from the buffer channels
    input wire logic bus_event_frame,
    input wire logic host_start_event,
    input wire logic host_change_event,
    // edge modes and acknowledge ownership
    input wire logic [1:0] capture_mode,
    input wire logic port_owner,
    input wire logic write_ack_en,
    // fieldbus side byte port, read only
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire dctc_pkg::dctc_addr_type bus_addr,
    input wire dctc_pkg::dctc_byte_type bus_wdata,
    output logic [7:0] bus_rdata,
    // process data side byte port
    input wire logic host_rd,
    input wire logic host_wr,
    input wire dctc_pkg::dctc_addr_type host_addr,
    input wire dctc_pkg::dctc_byte_type host_wdata,
    output logic [7:0] host_rdata,
    // status flags, fall in bit 1 and rise in bit 0
    output logic [1:0] event_flags
);
    import dctc_pkg::*;

    // every register of the block in one word
    typedef struct packed {
        logic cap_prev;
        logic [1:0] flag;
        logic [63:0] rise;
        logic [63:0] fall;
        logic [31:0] bchg;
        logic [31:0] hstart;
        logic [31:0] hchg;
        logic [55:0] snap_bus;
        logic [55:0] snap_host;
        logic [7:0] bus_rdata;
        logic [7:0] host_rdata;
    } dctc_state_type;

    dctc_state_type st_q;
    dctc_state_type st_d;
    logic rise_edge;
    logic fall_edge;
    logic [1:0] ack;
    logic [1:0] edge_seen;
    // acknowledge qualifiers per port
    logic bus_may_ack;
    logic host_rd_may_ack;
    logic host_wr_may_ack;

    // 8-byte blocks of the two edge stamps, for write acknowledges
    localparam logic [12:0] rise_blk = 13'(`DCTC_OFS_RISE >> 3);
    localparam logic [12:0] fall_blk = 13'(`DCTC_OFS_FALL >> 3);

    // reset image: stamps, flags, snapshots and read data all clear
    localparam dctc_state_type st_rst = '{
        cap_prev: 1'b0,
        flag: 2'b00,
        rise: `DCTC_RST_TIME64,
        fall: `DCTC_RST_TIME64,
        bchg: `DCTC_RST_TIME32,
        hstart: `DCTC_RST_TIME32,
        hchg: `DCTC_RST_TIME32,
        snap_bus: 56'h00000000000000,
        snap_host: 56'h00000000000000,
        bus_rdata: 8'h00,
        host_rdata: 8'h00
    };

    // a byte read: byte 0 is live, upper bytes come from this port's
    // snapshot; host-only stamps and unmapped bytes read as zero on the
    // bus side
    function automatic logic [7:0] rd_byte(input logic [15:0] a, input dctc_state_type s,
                                           input logic [55:0] snap, input logic host);
        logic [7:0] r;
        r = 8'h00;
        if (a == `DCTC_OFS_CTRL) begin
            r = {6'h00, capture_mode};
        end else if (a == `DCTC_OFS_STAT) begin
            // pin level in bit 2, fall flag in bit 1, rise flag in bit 0
            r[`DCTC_BIT_PIN] = s.cap_prev;
            r[`DCTC_BIT_FALL] = s.flag[1];
            r[`DCTC_BIT_RISE] = s.flag[0];
        end else if (a == `DCTC_OFS_RISE) begin
            r = s.rise[7:0];
        end else if (a > `DCTC_OFS_RISE && a < `DCTC_OFS_RISE + 16'h0008) begin
            r = snap[8 * (a[2:0] - 3'h1) +: 8];
        end else if (a == `DCTC_OFS_FALL) begin
            r = s.fall[7:0];
        end else if (a > `DCTC_OFS_FALL && a < `DCTC_OFS_FALL + 16'h0008) begin
            r = snap[8 * (a[2:0] - 3'h1) +: 8];
        end else if (a == `DCTC_OFS_BCHG) begin
            r = s.bchg[7:0];
        end else if (a > `DCTC_OFS_BCHG && a < `DCTC_OFS_BCHG + 16'h0004) begin
            r = snap[8 * (a[1:0] - 2'h1) +: 8];
        end else if (host && a == `DCTC_OFS_HSTART) begin
            r = s.hstart[7:0];
        end else if (host && a > `DCTC_OFS_HSTART && a < `DCTC_OFS_HSTART + 16'h0004) begin
            r = snap[8 * (a[1:0] - 2'h1) +: 8];
        end else if (host && a == `DCTC_OFS_HCHG) begin
            r = s.hchg[7:0];
        end else if (host && a > `DCTC_OFS_HCHG && a <= `DCTC_OFS_HCHG + 16'h0003) begin
            r = snap[8 * (a[1:0] - 2'h1) +: 8];
        end
        return r;
    endfunction

    // snapshot value taken on a low byte read; 32-bit stamps keep their
    // upper three bytes in the low end of the snapshot, and any other
    // address leaves the old snapshot in place
    function automatic logic [55:0] snap_next(input logic [15:0] a, input dctc_state_type s,
                                              input logic [55:0] old, input logic host);
        logic [55:0] n;
        n = old;
        if (a == `DCTC_OFS_RISE) begin
            n = s.rise[63:8];
        end else if (a == `DCTC_OFS_FALL) begin
            n = s.fall[63:8];
        end else if (a == `DCTC_OFS_BCHG) begin
            n = {32'h00000000, s.bchg[31:8]};
        end else if (host && a == `DCTC_OFS_HSTART) begin
            n = {32'h00000000, s.hstart[31:8]};
        end else if (host && a == `DCTC_OFS_HCHG) begin
            n = {32'h00000000, s.hchg[31:8]};
        end
        return n;
    endfunction

    // edge detect against the last cycle's pin sample; the sample clears
    // in reset, so a pin held low through reset gives no false edge
    assign rise_edge = capture_in & ~st_q.cap_prev;
    assign fall_edge = ~capture_in & st_q.cap_prev;
    assign edge_seen = {fall_edge, rise_edge};

    // bus side acknowledges by read only; bus_wr and the bus write data
    // never reach a stamp, so every bus write is dropped
    assign bus_may_ack = !port_owner && bus_rd;
    // host reads acknowledge only while write-ack is off
    assign host_rd_may_ack = port_owner && !write_ack_en && host_rd;
    // host writes are refused unless write-ack is on, and then only clear
    assign host_wr_may_ack = port_owner && write_ack_en && host_wr;

    // per flag acknowledge: a read must hit byte 0, a write any byte
    always_comb begin
        ack = 2'b00;
        if (bus_may_ack && bus_addr == `DCTC_OFS_RISE) ack[`DCTC_BIT_RISE] = 1'b1;
        if (bus_may_ack && bus_addr == `DCTC_OFS_FALL) ack[`DCTC_BIT_FALL] = 1'b1;
        if (host_rd_may_ack && host_addr == `DCTC_OFS_RISE) ack[`DCTC_BIT_RISE] = 1'b1;
        if (host_rd_may_ack && host_addr == `DCTC_OFS_FALL) ack[`DCTC_BIT_FALL] = 1'b1;
        if (host_wr_may_ack && host_addr[15:3] == rise_blk) ack[`DCTC_BIT_RISE] = 1'b1;
        if (host_wr_may_ack && host_addr[15:3] == fall_blk) ack[`DCTC_BIT_FALL] = 1'b1;
    end

    // next state: captures, flags, snapshots and read data
    always_comb begin
        st_d = st_q;
        st_d.cap_prev = capture_in;
        // stamps load only from the time inputs, never from write data;
        // in single mode a set flag freezes its stamp until acknowledged
        if (rise_edge && !(capture_mode[0] && st_q.flag[0])) st_d.rise = system_time;
        if (fall_edge && !(capture_mode[1] && st_q.flag[1])) st_d.fall = system_time;
        // flags: an acknowledge clears and a fresh single-mode edge sets;
        // the set looks at the old flag, so a second edge while the flag
        // stands is dropped and a same-cycle acknowledge still clears it
        for (int i = 0; i < 2; i++) begin
            if (ack[i]) st_d.flag[i] = 1'b0;
            if (edge_seen[i] && capture_mode[i] && !st_q.flag[i]) st_d.flag[i] = 1'b1;
            if (!capture_mode[i]) st_d.flag[i] = 1'b0;
        end
        // event stamps take local time in the cycle of their pulse
        if (bus_event_frame) st_d.bchg = local_time;
        if (host_start_event) st_d.hstart = local_time;
        if (host_change_event) st_d.hchg = local_time;
        // read data is registered and stands until the next read on that port;
        // a byte 0 read refreshes only that port's snapshot
        if (bus_rd) begin
            st_d.bus_rdata = rd_byte(bus_addr, st_q, st_q.snap_bus, 1'b0);
            st_d.snap_bus = snap_next(bus_addr, st_q, st_q.snap_bus, 1'b0);
        end
        if (host_rd) begin
            st_d.host_rdata = rd_byte(host_addr, st_q, st_q.snap_host, 1'b1);
            st_d.snap_host = snap_next(host_addr, st_q, st_q.snap_host, 1'b1);
        end
    end

    // state register; synchronous reset loads the reset image
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= st_rst;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs come straight from the state flip-flops
    assign bus_rdata = st_q.bus_rdata;
    assign host_rdata = st_q.host_rdata;
    assign event_flags = st_q.flag;
endmodule

//--- hw/dctc_params.svh
`ifndef DCTC_PARAMS_SVH
`define DCTC_PARAMS_SVH
// register byte addresses
`define DCTC_OFS_CTRL 16'h09a9
`define DCTC_OFS_STAT 16'h09af
`define DCTC_OFS_RISE 16'h09c0
`define DCTC_OFS_FALL 16'h09c8
`define DCTC_OFS_BCHG 16'h09f0
`define DCTC_OFS_HSTART 16'h09f8
`define DCTC_OFS_HCHG 16'h09fc
// field positions
`define DCTC_BIT_RISE 0
`define DCTC_BIT_FALL 1
`define DCTC_BIT_PIN 2
// reset values
`define DCTC_RST_TIME64 64'h0000000000000000
`define DCTC_RST_TIME32 32'h00000000
`endif

//--- hw/dctc_pkg.sv
package dctc_pkg;
    typedef logic [15:0] dctc_addr_type;
    typedef logic [7:0] dctc_byte_type;
    // access port of a register cycle
    typedef enum logic {
        DCTC_PORT_BUS,
        DCTC_PORT_HOST
    } dctc_port_type;
endpackage

//--- test/dctc_capture_props.sv
`timescale 1ns/1ps
// read data and flags at the block's ports
module dctc_capture_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] capture_mode,
    input wire logic bus_rd,
    input wire dctc_pkg::dctc_addr_type bus_addr,
    input wire logic [7:0] bus_rdata,
    input wire logic host_rd,
    input wire dctc_pkg::dctc_addr_type host_addr,
    input wire logic [7:0] host_rdata,
    input wire logic [1:0] event_flags
);
    import dctc_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    a_bus_data_hold: assert property (!bus_rd |=> $stable(bus_rdata))
        else $error("bus data moved");
    a_host_data_hold: assert property (!host_rd |=> $stable(host_rdata))
        else $error("host data moved");
    a_host_only_zero: assert property (bus_rd && bus_addr[15:3] == 13'h013f |=> bus_rdata == 8'h00)
        else $error("host stamp seen on bus");
    a_mode_readback: assert property (bus_rd && bus_addr == 16'h09a9 |=> bus_rdata[1:0] == $past(capture_mode))
        else $error("mode readback");
    a_flag_readback: assert property (host_rd && host_addr == 16'h09af |=> host_rdata[1:0] == $past(event_flags))
        else $error("status readback");
    a_rise_cont_clear: assert property (!capture_mode[0] [*2] |-> !event_flags[0])
        else $error("rise flag in continuous");
    a_fall_cont_clear: assert property (!capture_mode[1] [*2] |-> !event_flags[1])
        else $error("fall flag in continuous");
    a_rise_single_only: assert property ($rose(event_flags[0]) |-> $past(capture_mode[0]))
        else $error("rise flag without single");
endmodule
bind dctc_capture_regs dctc_capture_props i_dctc_capture_props (.clk(clk), .sys_rst(sys_rst),
    .capture_mode(capture_mode), .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_rdata(bus_rdata),
    .host_rd(host_rd), .host_addr(host_addr), .host_rdata(host_rdata), .event_flags(event_flags));

//--- test/dctc_time_src.sv
`timescale 1ns/1ps
// far-side time base; the bench freezes it around captures
module dctc_time_src (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run,
    output logic [63:0] system_time,
    output logic [31:0] local_time
);
    // every byte moves per tick so stale bytes show
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            system_time <= 64'h0123456789abcdef;
        end else if (run) begin
            system_time <= system_time + 64'h0101010101010101;
        end
    end
    assign local_time = system_time[31:0];
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
    import dctc_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, capture_in = 1'b0, run = 1'b1, port_owner = 1'b0;
    logic bus_event_frame = 1'b0, host_start_event = 1'b0, host_change_event = 1'b0;
    logic bus_rd = 1'b0, bus_wr = 1'b0, host_rd = 1'b0, host_wr = 1'b0, write_ack_en = 1'b0;
    logic [1:0] capture_mode = 2'h0, event_flags;
    dctc_addr_type bus_addr = 16'h0000, host_addr = 16'h0000;
    dctc_byte_type bus_wdata = 8'h00, host_wdata = 8'h00;
    logic [7:0] bus_rdata, host_rdata, d;
    logic [63:0] system_time, t1, r, v;
    logic [31:0] local_time;
    int failures = 0, total_checks = 0;
    always #12.5 clk = ~clk;
    dctc_time_src i_dctc_time_src (.clk(clk), .sys_rst(sys_rst), .run(run),
        .system_time(system_time), .local_time(local_time));
    dctc_capture_regs i_dctc_capture_regs (.clk(clk), .sys_rst(sys_rst),
        .capture_in(capture_in), .system_time(system_time), .local_time(local_time),
        .bus_event_frame(bus_event_frame), .host_start_event(host_start_event),
        .host_change_event(host_change_event), .capture_mode(capture_mode),
        .port_owner(port_owner), .write_ack_en(write_ack_en), .bus_rd(bus_rd),
        .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .event_flags(event_flags));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one byte access on either port
    task automatic acc(input logic h, input logic w, input dctc_addr_type a);
        @(negedge clk);
        {host_rd, host_wr, bus_rd, bus_wr} = {h & !w, h & w, !h & !w, !h & w};
        bus_addr = a;
        host_addr = a;
        @(negedge clk);
        {host_rd, host_wr, bus_rd, bus_wr} = 4'h0;
        @(negedge clk);
        d = h ? host_rdata : bus_rdata;
    endtask
    task automatic rdn(input logic h, input dctc_addr_type a, input int n);
        v = 64'h0;
        for (int i = 0; i < n; i++) begin
            acc(h, 1'b0, a + 16'(i));
            v[8*i +: 8] = d;
        end
    endtask
    // drive the pin with time frozen, keep edge time in t1
    task automatic pin(input logic lv);
        @(negedge clk);
        run = 1'b0;
        capture_in = lv;
        t1 = system_time;
        repeat (4) @(negedge clk);
        run = 1'b1;
    endtask
    task automatic s_cont();
        pin(1'b1);
        r = t1;
        pin(1'b0);
        rdn(1'b0, 16'h09c8, 8);
        chk(v, t1);
        acc(1'b0, 1'b0, 16'h09c0);
        chk(d, r[7:0]);
        acc(1'b1, 1'b0, 16'h09c8);
        pin(1'b1);
        rdn(1'b0, 16'h09c1, 7);
        chk(v[55:0], r[63:8]);
        rdn(1'b0, 16'h09c0, 8);
        chk(v, t1);
        chk(event_flags, 2'h0);
    endtask
    task automatic s_single();
        capture_mode = 2'h1;
        pin(1'b0);
        pin(1'b1);
        r = t1;
        pin(1'b0);
        pin(1'b1);
        chk(event_flags, 2'h1);
        rdn(1'b0, 16'h09c0, 8);
        chk(v, r);
        chk(event_flags, 2'h0);
    endtask
    task automatic s_host();
        {capture_mode, port_owner} = 3'h7;
        pin(1'b0);
        pin(1'b1);
        acc(1'b0, 1'b0, 16'h09a9);
        chk(d, 8'h03);
        acc(1'b1, 1'b1, 16'h09c0);
        acc(1'b0, 1'b0, 16'h09c0);
        acc(1'b1, 1'b0, 16'h09af);
        chk(d, 8'h07);
        acc(1'b1, 1'b0, 16'h09c0);
        chk(event_flags, 2'h2);
        acc(1'b1, 1'b0, 16'h09c8);
        chk(event_flags, 2'h0);
    endtask
    task automatic s_wack();
        {write_ack_en, bus_wdata} = {1'b1, 8'ha5};
        pin(1'b0);
        pin(1'b1);
        acc(1'b0, 1'b1, 16'h09c0);
        acc(1'b1, 1'b0, 16'h09c0);
        chk(event_flags, 2'h3);
        acc(1'b1, 1'b1, 16'h09c8);
        chk(event_flags, 2'h1);
        acc(1'b1, 1'b1, 16'h09c3);
        chk(event_flags, 2'h0);
        rdn(1'b0, 16'h09c0, 8);
        chk(v, t1);
    endtask
    task automatic s_evt();
        @(negedge clk);
        run = 1'b0;
        {bus_event_frame, host_start_event, host_change_event} = 3'h7;
        @(negedge clk);
        {bus_event_frame, host_start_event, host_change_event} = 3'h0;
        repeat (3) @(negedge clk);
        r = {32'h0, local_time};
        run = 1'b1;
        rdn(1'b0, 16'h09f0, 4);
        chk(v, r);
        rdn(1'b1, 16'h09f8, 4);
        chk(v, r);
        rdn(1'b0, 16'h09f8, 4);
        chk(v, 64'h0);
        rdn(1'b1, 16'h09fc, 4);
        chk(v, r);
        rdn(1'b0, 16'h09fc, 4);
        chk(v, 64'h0);
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        s_cont();
        s_single();
        s_host();
        s_wack();
        s_evt();
        wrap_up();
    end
endmodule
